// [logic/sbcs_top.sv]
// Burst address sequencing and sleep control of the burst SRAM, with an APB slave.
`timescale 1ns/1ps
// Behaviour
// - Linear order increments low bits modulo four.
// - Interleaved order XORs start with count.
// - Sleep entered two cycles after request rises.
// - Burst state and access address kept during sleep.
// - Normal operation two cycles after request falls.
// - Asleep: deselected, inputs ignored, outputs off.
// - Sleep request is asynchronous and active high.
// - Sleep holds for as long as request stays high.
// - Order select low linear, high interleaved.
// - Advance steps counter, low loads start.
// - Burst counter is two bits wide.
// - Clock hold freezes counter and access state while awake or entering sleep.
module sbcs_top (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sbcs_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleepRequest,
	input wire logic burstOrderSelect,
	input wire logic advanceLoad,
	input wire logic clockHold,
	input wire logic chipSelectN,
	input wire logic writeN,
	input wire logic [sbcs_pkg::ADDR_W-1:0] extAddr,
	output logic [sbcs_pkg::ADDR_W-1:0] accessAddr,
	output logic accessValid,
	output logic dqOutEnable,
	output logic sleepActive
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	sbcs_pkg::sbcs_top_state_t st; // Registered block state.
	sbcs_pkg::sbcs_top_state_t next_st; // Next block state.
	sbcs_pkg::sbcs_burst_cmd_t burstCmd; // Command to the burst counter.
	logic [1:0] syncPins; // Synchronised sleep request and order pin.
	logic syncReq; // Synchronised sleep request.
	logic syncOrder; // Synchronised burst order pin.
	logic effOrder; // Burst order in effect.
	logic operating; // Device answers commands this cycle.
	logic stepping; // Device takes its synchronous inputs this cycle.
	logic [sbcs_pkg::BURST_W-1:0] lowAddr; // Low address bits from the counter.
	logic [sbcs_pkg::BURST_W-1:0] burstCount; // Steps taken since the load.
	logic apbSetup; // APB setup phase.
	logic apbWrite; // APB write completes this cycle.
	logic [31:0] readData; // Read value for the addressed register.
	logic readErr; // Address is unmapped.

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// The sleep request is not qualified by the clock, so it is brought into the
	// domain before any state looks at it; the order pin is a strap and rides along.
	sbcs_sync #(
		.WIDTH(2)
	) u_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.asyncIn({burstOrderSelect, sleepRequest}),
		.syncOut(syncPins)
	);

	assign syncReq = syncPins[0];
	assign syncOrder = syncPins[1];

	// ------------------------------------------------------------
	// Burst counter
	// ------------------------------------------------------------
	// Software may take the order over from the pin; after reset the pin rules.
	assign effOrder = st.control[sbcs_pkg::CTRL_OVR_EN_BIT] ?
		st.control[sbcs_pkg::CTRL_OVR_VAL_BIT] : syncOrder;

	// Commands are taken while awake or still entering sleep.
	assign operating = (st.sleepState == sbcs_pkg::SLP_AWAKE) ||
		(st.sleepState == sbcs_pkg::SLP_ENTERING);

	// A held clock edge is ignored by the access path while operating.
	assign stepping = operating && !clockHold;

	// Load on a selected command with advance low; step on advance within a burst.
	always_comb begin
		burstCmd.load = stepping && !advanceLoad && !chipSelectN;
		burstCmd.advance = stepping && advanceLoad && st.burstActive;
		burstCmd.interleaved = effOrder;
		burstCmd.start = extAddr[sbcs_pkg::BURST_W-1:0];
	end

	sbcs_burst_counter u_counter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.cmd(burstCmd),
		.lowAddr(lowAddr),
		.burstCount(burstCount)
	);

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pwrite;

	// Read value of the addressed register; unmapped addresses answer with an error.
	always_comb begin
		readData = 32'h00000000;
		readErr = 1'b0;
		unique case (paddr)
			sbcs_pkg::REG_CONTROL: begin
				readData[1:0] = st.control;
			end
			sbcs_pkg::REG_STATUS: begin
				readData[sbcs_pkg::STAT_SLEEP_LSB +: 4] = st.sleepState;
				readData[sbcs_pkg::STAT_BURST_BIT] = st.burstActive;
				readData[sbcs_pkg::STAT_COUNT_LSB +: 2] = burstCount;
				readData[sbcs_pkg::STAT_ORDER_BIT] = effOrder;
				readData[sbcs_pkg::STAT_REQ_BIT] = syncReq;
			end
			sbcs_pkg::REG_ACCESS_ADDR: begin
				readData[sbcs_pkg::ADDR_W-1:0] = {st.accessHigh, lowAddr};
			end
			sbcs_pkg::REG_SLEEP_COUNT: begin
				readData[sbcs_pkg::ENTRY_CNT_W-1:0] = st.sleepEntries;
			end
			default: begin
				readErr = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Sleep sequencing runs on every edge, whatever the clock hold says.
		unique case (st.sleepState)
			sbcs_pkg::SLP_AWAKE: begin
				// A request seen here starts the entry delay.
				if (syncReq) begin
					next_st.sleepState = sbcs_pkg::SLP_ENTERING;
					next_st.sleepCnt = sbcs_pkg::SLEEP_CNT_FIRST;
				end
			end
			sbcs_pkg::SLP_ENTERING: begin
				// A request that drops early returns to normal at once.
				if (!syncReq) begin
					next_st.sleepState = sbcs_pkg::SLP_AWAKE;
				end else if (st.sleepCnt == sbcs_pkg::SLEEP_ENTRY_LAST) begin
					next_st.sleepState = sbcs_pkg::SLP_ASLEEP;
					next_st.sleepEntries = sbcs_pkg::ENTRY_CNT_W'(st.sleepEntries + 16'h0001);
				end else begin
					next_st.sleepCnt = sbcs_pkg::SLEEP_CNT_W'(st.sleepCnt + 2'h1);
				end
			end
			sbcs_pkg::SLP_ASLEEP: begin
				// Sleep is held for as long as the request stays high.
				if (!syncReq) begin
					next_st.sleepState = sbcs_pkg::SLP_WAKING;
					next_st.sleepCnt = sbcs_pkg::SLEEP_CNT_FIRST;
				end
			end
			sbcs_pkg::SLP_WAKING: begin
				// A fresh request during recovery goes straight back to sleep.
				if (syncReq) begin
					next_st.sleepState = sbcs_pkg::SLP_ASLEEP;
				end else if (st.sleepCnt == sbcs_pkg::SLEEP_RECOVERY_LAST) begin
					next_st.sleepState = sbcs_pkg::SLP_AWAKE;
				end else begin
					next_st.sleepCnt = sbcs_pkg::SLEEP_CNT_W'(st.sleepCnt + 2'h1);
				end
			end
			default: begin
				// An illegal code recovers to the awake state.
				next_st.sleepState = sbcs_pkg::SLP_AWAKE;
				next_st.sleepCnt = 2'h0;
			end
		endcase

		// Access path: commands are taken only while operating and not held.
		if (stepping) begin
			if (!advanceLoad) begin
				if (!chipSelectN) begin
					// New burst from the external address.
					next_st.accessHigh = extAddr[sbcs_pkg::ADDR_W-1:sbcs_pkg::BURST_W];
					next_st.accessValid = 1'b1;
					next_st.burstActive = 1'b1;
					next_st.dqOutEnable = writeN;
					next_st.burstRead = writeN;
				end else begin
					// Deselect ends any open burst.
					next_st.accessValid = 1'b0;
					next_st.burstActive = 1'b0;
					next_st.dqOutEnable = 1'b0;
				end
			end else if (!st.burstActive) begin
				// Continue after a deselect stays deselected.
				next_st.accessValid = 1'b0;
				next_st.dqOutEnable = 1'b0;
			end else begin
				// Continue within the burst; this also brings the outputs back after sleep.
				next_st.accessValid = 1'b1;
				next_st.dqOutEnable = st.burstRead;
			end
		end else if (!operating) begin
			// Asleep or recovering: deselected, burst state and address kept.
			next_st.accessValid = 1'b0;
			next_st.dqOutEnable = 1'b0;
		end

		// Register writes complete in the access phase, which never waits.
		if (apbWrite && paddr == sbcs_pkg::REG_CONTROL) begin
			next_st.control = pwdata[1:0];
		end

		// Read data and error are captured in the setup phase for the access phase.
		if (apbSetup) begin
			next_st.prdata = pwrite ? 32'h00000000 : readData;
			next_st.pslverr = readErr;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st <= sbcs_pkg::TOP_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata = st.prdata;
	assign pslverr = st.pslverr;
	assign pready = psel && penable; // Zero wait states.
	assign accessAddr = {st.accessHigh, lowAddr};
	assign accessValid = st.accessValid;
	assign dqOutEnable = st.dqOutEnable;
	assign sleepActive = (st.sleepState == sbcs_pkg::SLP_ASLEEP);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Request seen while awake and then held for one more cycle.
	sequence reqRiseHeld;
		st.sleepState == sbcs_pkg::SLP_AWAKE && syncReq ##1 syncReq;
	endsequence

	// Request seen low while asleep and then held low one more cycle.
	sequence reqFallHeld;
		st.sleepState == sbcs_pkg::SLP_ASLEEP && !syncReq ##1 !syncReq;
	endsequence

	sync_delay_a: assert property (
		syncReq == $past(sleepRequest, 2))
		else $error("Sleep request not delayed by two flops.");

	sleep_entry_a: assert property (
		reqRiseHeld |=> st.sleepState == sbcs_pkg::SLP_ASLEEP)
		else $error("Sleep not entered two cycles after the request.");

	sleep_exit_a: assert property (
		reqFallHeld |=> st.sleepState == sbcs_pkg::SLP_AWAKE)
		else $error("Normal operation not resumed two cycles after release.");

	sleep_hold_a: assert property (
		st.sleepState == sbcs_pkg::SLP_ASLEEP && syncReq |=> sleepActive)
		else $error("Sleep left while the request stayed high.");

	entry_abort_a: assert property (
		st.sleepState == sbcs_pkg::SLP_ENTERING && !syncReq |=> !sleepActive)
		else $error("Sleep entered after the request dropped.");

	asleep_quiet_a: assert property (
		!operating ##1 !operating |-> !accessValid && !dqOutEnable)
		else $error("Outputs active while asleep.");

	state_kept_a: assert property (
		!operating ##1 !operating |-> $stable(accessAddr) && $stable(st.burstActive))
		else $error("Internal state changed during sleep.");

	clock_hold_a: assert property (
		clockHold && operating |=> $stable(accessAddr) && $stable(accessValid))
		else $error("Held clock edge changed the access state.");

	load_addr_a: assert property (
		burstCmd.load |=> accessAddr == $past(extAddr) && accessValid)
		else $error("Load did not take the external address.");
endmodule

// [logic/sbcs_pkg.sv]
// Shared constants, encodings and carrier types of the burst counter and sleep control.
package sbcs_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 21; // Full external address width.
	localparam int APB_ADDR_W = 12; // APB byte address width.
	localparam int BURST_W = 2; // Burst counter covers the two low address bits.
	localparam int SLEEP_CNT_W = 2; // Width of the entry and exit delay counter.
	localparam int ENTRY_CNT_W = 16; // Width of the sleep entry event counter.

	// ------------------------------------------------------------
	// Sleep timing, in clock cycles
	// ------------------------------------------------------------
	localparam int SLEEP_ENTRY_TIME = 2; // Entry delay, in cycles.
	localparam int SLEEP_RECOVERY_TIME = 2; // Wake-up delay, in cycles.
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_ENTRY_LAST = SLEEP_CNT_W'(SLEEP_ENTRY_TIME - 1);
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_RECOVERY_LAST = SLEEP_CNT_W'(SLEEP_RECOVERY_TIME - 1);
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_FIRST = 2'h1; // Count on the first delay cycle.

	// ------------------------------------------------------------
	// Register map (byte addresses) and field positions
	// ------------------------------------------------------------
	localparam logic [APB_ADDR_W-1:0] REG_CONTROL = 12'h000; // Burst order override.
	localparam logic [APB_ADDR_W-1:0] REG_STATUS = 12'h004; // Sleep and burst state.
	localparam logic [APB_ADDR_W-1:0] REG_ACCESS_ADDR = 12'h008; // Last access address.
	localparam logic [APB_ADDR_W-1:0] REG_SLEEP_COUNT = 12'h00c; // Sleep entries seen.
	localparam int CTRL_OVR_EN_BIT = 0; // Take burst order from the register.
	localparam int CTRL_OVR_VAL_BIT = 1; // Burst order when overridden.
	localparam int STAT_SLEEP_LSB = 0; // One-hot sleep state, four bits.
	localparam int STAT_BURST_BIT = 4; // A burst is open.
	localparam int STAT_COUNT_LSB = 5; // Burst count, two bits.
	localparam int STAT_ORDER_BIT = 7; // Burst order in effect.
	localparam int STAT_REQ_BIT = 8; // Synchronised sleep request.
	localparam logic [1:0] CONTROL_RESET = 2'h0; // Order follows the pin after reset.

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SLP_AWAKE = 4'h1,
		SLP_ENTERING = 4'h2,
		SLP_ASLEEP = 4'h4,
		SLP_WAKING = 4'h8
	} sbcs_sleep_state_t;

	typedef struct packed {
		logic load; // Load a new start value.
		logic advance; // Step to the next burst address.
		logic interleaved; // High selects interleaved order.
		logic [BURST_W-1:0] start; // Start value from the external address.
	} sbcs_burst_cmd_t;

	typedef struct packed {
		logic [BURST_W-1:0] start;
		logic [BURST_W-1:0] count;
		logic [BURST_W-1:0] low;
	} sbcs_ctr_state_t;

	typedef struct packed {
		sbcs_sleep_state_t sleepState;
		logic [SLEEP_CNT_W-1:0] sleepCnt;
		logic [1:0] control;
		logic [ADDR_W-1:BURST_W] accessHigh;
		logic accessValid;
		logic dqOutEnable;
		logic burstRead; // Direction of the open burst, kept through sleep.
		logic burstActive;
		logic [ENTRY_CNT_W-1:0] sleepEntries;
		logic [31:0] prdata;
		logic pslverr;
	} sbcs_top_state_t;

	localparam sbcs_ctr_state_t CTR_RESET = '{start: 2'h0, count: 2'h0, low: 2'h0};
	localparam sbcs_top_state_t TOP_RESET = '{sleepState: SLP_AWAKE, sleepCnt: 2'h0,
		control: CONTROL_RESET, accessHigh: '0, accessValid: 1'b0, dqOutEnable: 1'b0,
		burstRead: 1'b0, burstActive: 1'b0, sleepEntries: 16'h0000,
		prdata: 32'h00000000, pslverr: 1'b0};

endpackage

// [logic/sbcs_sync.sv]
// Two-flip-flop synchroniser for levels that arrive from outside the clock domain.
`timescale 1ns/1ps
module sbcs_sync #(
	parameter int WIDTH = 2
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] meta; // First stage, read only by the second.
		logic [WIDTH-1:0] stable; // Second stage, safe to use.
	} sbcs_sync_state_t;

	sbcs_sync_state_t st; // Registered state.
	sbcs_sync_state_t next_st; // Next state.

	// Shift the input through both stages.
	always_comb begin
		next_st.meta = asyncIn;
		next_st.stable = st.meta;
	end

	// Both stages clear to low, the idle level of the sampled pins.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign syncOut = st.stable;
endmodule

// [logic/sbcs_burst_counter.sv]
// Two-bit burst address counter with linear and interleaved order.
`timescale 1ns/1ps
module sbcs_burst_counter (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire sbcs_pkg::sbcs_burst_cmd_t cmd,
	output logic [sbcs_pkg::BURST_W-1:0] lowAddr,
	output logic [sbcs_pkg::BURST_W-1:0] burstCount
);
	sbcs_pkg::sbcs_ctr_state_t st; // Registered counter state.
	sbcs_pkg::sbcs_ctr_state_t next_st; // Next counter state.
	logic [sbcs_pkg::BURST_W-1:0] stepCount; // Count after one step.

	// ------------------------------------------------------------
	// Next address
	// ------------------------------------------------------------
	// The count is two bits wide, so the fourth step wraps it back to zero and the
	// sequence repeats from the loaded start until a new load.
	always_comb begin
		next_st = st;
		stepCount = sbcs_pkg::BURST_W'(st.count + 2'h1);
		if (cmd.load) begin
			next_st.start = cmd.start;
			next_st.count = 2'h0;
			next_st.low = cmd.start;
		end else if (cmd.advance) begin
			next_st.count = stepCount;
			if (cmd.interleaved) begin
				next_st.low = st.start ^ stepCount;
			end else begin
				next_st.low = sbcs_pkg::BURST_W'(st.start + stepCount);
			end
		end
	end

	// Counter register.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st <= sbcs_pkg::CTR_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign lowAddr = st.low;
	assign burstCount = st.count;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	linear_step_a: assert property (
		cmd.advance && !cmd.load && !cmd.interleaved |=>
		lowAddr == 2'($past(st.start) + $past(burstCount) + 2'h1))
		else $error("Linear burst address is not start plus count.");

	burst_wrap_a: assert property (
		cmd.advance && !cmd.load && burstCount == 2'h3 |=> lowAddr == $past(st.start))
		else $error("Burst did not wrap to its start on the fifth clock.");

	burst_load_a: assert property (
		cmd.load |=> lowAddr == $past(cmd.start) && burstCount == 2'h0)
		else $error("Load did not take the external start value.");
endmodule

// [sim/sbcs_mem_ctrl.sv]
// Memory controller model that drives the command, burst and sleep pins of the block.
`timescale 1ns/1ps
module sbcs_mem_ctrl (
	input wire logic ref_clk,
	output logic sleepRequest,
	output logic advanceLoad,
	output logic clockHold,
	output logic chipSelectN,
	output logic writeN,
	output logic [sbcs_pkg::ADDR_W-1:0] extAddr
);

	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	// Starts deselected, with the sleep request held low.
	initial begin
		sleepRequest = 1'b0; // Low during normal operation.
		advanceLoad = 1'b0;
		clockHold = 1'b0;
		chipSelectN = 1'b1;
		writeN = 1'b1;
		extAddr = '0;
	end

	// ------------------------------------------------------------
	// Commands
	// ------------------------------------------------------------
	// One command for one cycle: kind 0 loads, 1 advances, 2 deselects.
	// A deselected address bus is not valid, so it shows the inverse of the last value.
	task automatic cmd(input logic [1:0] kind, input logic [20:0] a, input logic rd,
		input logic hold);
		@(posedge ref_clk);
		advanceLoad <= (kind == 2'h1);
		chipSelectN <= (kind == 2'h2);
		writeN <= rd;
		extAddr <= (kind == 2'h2) ? ~extAddr : a;
		clockHold <= hold;
	endtask

	// Moves the sleep request; the bench calls it only while a read burst is open and the clock is held.
	task automatic sleep(input logic level);
		@(posedge ref_clk);
		sleepRequest <= level;
	endtask

endmodule

// [sim/tb_top.sv]
// Self-checking testbench of the burst counter and sleep control.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
	$display("BAD %s exp=%h got=%h", nm, ex, got); end end
module tb_top;

	// ------------------------------------------------------------
	// Signals and bookkeeping
	// ------------------------------------------------------------
	typedef struct {int due; logic v; logic dq; logic [20:0] ad;} sbcs_exp_t;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, burstOrderSelect, sleepRequest, advanceLoad, clockHold;
	logic chipSelectN, writeN, accessValid, dqOutEnable, sleepActive;
	logic [20:0] extAddr, accessAddr;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h0aac;
	sbcs_exp_t expq[$];
	sbcs_exp_t me;

	sbcs_top DUT (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleepRequest(sleepRequest), .burstOrderSelect(burstOrderSelect),
		.advanceLoad(advanceLoad), .clockHold(clockHold), .chipSelectN(chipSelectN),
		.writeN(writeN), .extAddr(extAddr), .accessAddr(accessAddr),
		.accessValid(accessValid), .dqOutEnable(dqOutEnable), .sleepActive(sleepActive));

	sbcs_mem_ctrl ctl (.ref_clk(ref_clk), .sleepRequest(sleepRequest),
		.advanceLoad(advanceLoad), .clockHold(clockHold), .chipSelectN(chipSelectN),
		.writeN(writeN), .extAddr(extAddr));

	// Clock of 100 ns period and a cycle count used to time expectations.
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Xorshift generator with a fixed start value.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Builds one expected access result.
	function automatic sbcs_exp_t mk(input logic v, input logic dq, input logic [20:0] ad);
		sbcs_exp_t e;
		e = '{0, v, dq, ad};
		return e;
	endfunction

	// Issues one command and notes what the next edge must show.
	task automatic step(input logic [1:0] k, input logic [20:0] a, input logic rd,
		input logic hold, input sbcs_exp_t e);
		ctl.cmd(k, a, rd, hold);
		@(negedge ref_clk);
		e.due = cyc + 1;
		expq.push_back(e);
	endtask

	// Loads a start value and advances seven times, crossing the wrap.
	task automatic burst(input logic o, input logic [1:0] s, input logic [20:0] a,
		input logic rd);
		logic [1:0] lo;
		step(2'h0, {a[20:2], s}, rd, 1'b0, mk(1'b1, rd, {a[20:2], s}));
		for (int n = 1; n < 8; n++) begin
			lo = o ? (s ^ 2'(n)) : (s + 2'(n));
			step(2'h1, a, rd, 1'b0, mk(1'b1, rd, {a[20:2], lo}));
		end
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic results();
		// Notes never taken off the queue count together as a single mismatch.
		if (expq.size() != 0) begin
			miscompares++;
		end
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Result monitor
	// ------------------------------------------------------------
	// Takes each due note off the queue and compares it with the access outputs.
	always @(negedge ref_clk) begin
		while (expq.size() > 0 && expq[0].due == cyc) begin
			me = expq.pop_front();
			`CHK("accessValid", me.v, accessValid) // Taken or deselected.
			`CHK("dqOutEnable", me.dq, dqOutEnable) // Read burst drives.
			if (me.v) begin
				`CHK("accessAddr", me.ad, accessAddr) // Burst order.
			end
		end
	end

	// Cuts a hang short after far more cycles than the tests need.
	initial begin
		#(5000 * 100);
		miscompares++;
		results();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] rv;
		logic er;
		logic [20:0] held;
		int g;
		burstOrderSelect = 1'b0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		// Every start value in both orders, chosen by the pin.
		for (int o = 0; o < 2; o++) begin
			@(posedge ref_clk);
			burstOrderSelect <= o[0];
			repeat (3) @(posedge ref_clk);
			for (int s = 0; s < 4; s++) begin
				rv = rnd();
				burst(o[0], s[1:0], rv[20:0], rv[31]); // Pin picks order.
			end
		end
		// Deselect, then an advance that must stay deselected.
		step(2'h2, 21'h0, 1'b1, 1'b0, mk(1'b0, 1'b0, 21'h0));
		step(2'h1, 21'h0, 1'b1, 1'b0, mk(1'b0, 1'b0, 21'h0));
		// Register override of the order, an unmapped address and the read-back.
		apb(1'b1, 12'h000, 32'h3, rv, er);
		apb(1'b0, 12'h000, 32'h0, rv, er);
		`CHK("control", 32'h3, rv) // Override reads back.
		@(posedge ref_clk);
		burstOrderSelect <= 1'b0;
		repeat (3) @(posedge ref_clk);
		burst(1'b1, 2'h1, 21'h12345, 1'b1); // Override wins over the pin.
		apb(1'b1, 12'h000, 32'h0, rv, er);
		apb(1'b0, 12'h010, 32'h0, rv, er);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0, rv)
		// Open a read burst, freeze it, then sleep and wake.
		burst(1'b0, 2'h1, 21'h0abcd, 1'b1);
		held = {19'h02af3, 2'h0};
		step(2'h1, held, 1'b1, 1'b1, mk(1'b1, 1'b1, held)); // Held edge.
		step(2'h1, held, 1'b1, 1'b1, mk(1'b1, 1'b1, held)); // Held edge.
		ctl.sleep(1'b1);
		g = 0;
		do begin
			@(negedge ref_clk);
			g++;
		end while (sleepActive !== 1'b1 && g < 20);
		`CHK("entry edges", 5, g) // One idle negedge, two sync flops, two entry.
		ctl.cmd(2'h0, ~held, 1'b0, 1'b0);
		repeat (6) begin
			@(negedge ref_clk);
			`CHK("sleepActive", 1'b1, sleepActive) // Request still high.
			`CHK("asleep valid", 1'b0, accessValid) // Load ignored.
			`CHK("asleep dq", 1'b0, dqOutEnable) // Outputs off.
			`CHK("asleep addr", held, accessAddr) // State kept.
		end
		ctl.cmd(2'h1, held, 1'b1, 1'b1);
		ctl.sleep(1'b0);
		g = 0;
		do begin
			@(negedge ref_clk);
			g++;
		end while (sleepActive !== 1'b0 && g < 20);
		`CHK("exit edges", 4, g) // One idle negedge, two sync flops, then leave.
		// Only reads follow the wake-up, and the burst continues.
		step(2'h1, held, 1'b1, 1'b0, mk(1'b1, 1'b1, {held[20:2], 2'h1}));
		step(2'h2, 21'h0, 1'b1, 1'b0, mk(1'b0, 1'b0, 21'h0));
		apb(1'b0, 12'h00c, 32'h0, rv, er);
		`CHK("sleep count", 32'h1, rv) // One entry seen.
		apb(1'b0, 12'h004, 32'h0, rv, er);
		`CHK("status state", 4'h1, rv[3:0]) // Awake again.
		repeat (3) @(posedge ref_clk);
		results();
	end

endmodule
